// ==== verilog/tsd_pkg.sv ====
// Notes on behaviour
// RULE1 - Channel 1 mode bit set runs carrier 1 as AM, clear as FM.
// RULE2 - Ident timing 00 slow, 01 medium, 10 fast, 11 off and held reset.
// RULE3 - Channel 2 mode 00 FM, 01 AM, 10 NICAM.
// RULE4 - Bandwidth 00 N/N, 01 extra-wide/N with FM on channel 1 only, 10 M/M, 11 W/W.
// RULE5 - Identification off puts its hardware into a defined reset state.
// RULE6 - De-emphasis low nibble drives carrier 1, high nibble carrier 2.
// RULE7 - De-emphasis code 000 50us, 001 60us, 010 75us, 011 J17, 100 off.
// RULE8 - Adaptive bit enables adaptive de-emphasis for its carrier; software sets 75us.
// RULE9 - FM and NICAM de-emphasis have unity gain at the low reference frequency.
// RULE10 - Auto dematrix follows ident result, ignores manual code, region picks stereo matrix.
// RULE11 - Auto dematrix with channel 2 in NICAM gives CH1 on both outputs.
// RULE12 - Manual dematrix codes 000 to 110 select the documented left/right pairs.
// RULE13 - Auto: mono CH1/CH1, Europe 2CH1-CH2/CH2, Korea sum/diff, dual CH1/CH2.
// RULE14 - Trim bit 4 clear gives +nibble dB, set gives nibble minus 15; 1111 undefined.
// RULE15 - Channel 1 trim gain also applies to the mono feed.
// RULE16 - Channel 2 trim acts in FM/AM; software sets equal trims for stereo.
// RULE17 - Oscillator test only in FM mode; pull bit set picks lower frequency. The code allows the test whenever channel 2 is not NICAM.
// RULE18 - Data output enable drives serial stream and clock, else both high impedance.
// RULE19 - Fallback source bit picks mono input when auto-mute on and DAC selected.
// RULE20 - Digital output fallback always between NICAM and the first carrier.
// RULE21 - NICAM de-emphasis bit set disables J17 on the NICAM path.
// RULE22 - Auto-mute disable clear with NICAM switches source by bit error rate.
// RULE23 - Reselect NICAM when error count is below the lower limit, reset 0x14.
// RULE24 - Switch to fallback when error count exceeds the upper limit, reset 0x50.
package tsd_pkg;
  // ----------------------------------------
  // Register subaddresses
  // ----------------------------------------
  localparam logic [7:0] TSD_ADDR_DEMOD  = 8'h09;
  localparam logic [7:0] TSD_ADDR_DEEMPH = 8'h0A;
  localparam logic [7:0] TSD_ADDR_MATRIX = 8'h0B;
  localparam logic [7:0] TSD_ADDR_TRIM1  = 8'h0C;
  localparam logic [7:0] TSD_ADDR_TRIM2  = 8'h0D;
  localparam logic [7:0] TSD_ADDR_DIGCFG = 8'h0E;
  localparam logic [7:0] TSD_ADDR_LOWER  = 8'h10;
  localparam logic [7:0] TSD_ADDR_UPPER  = 8'h11;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] TSD_RST_ZERO  = 8'h00;
  localparam logic [7:0] TSD_RST_LOWER = 8'h14;
  localparam logic [7:0] TSD_RST_UPPER = 8'h50;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int TSD_DM_CH1AM     = 0;
  localparam int TSD_DM_BW_LO     = 1;
  localparam int TSD_DM_CH2_LSB   = 2;
  localparam int TSD_DM_BW_HI     = 4;
  localparam int TSD_DM_REGION    = 5;
  localparam int TSD_DM_IDENT_LSB = 6;
  localparam int TSD_DE_CODE1_LSB = 0;
  localparam int TSD_DE_ADAPT1    = 3;
  localparam int TSD_DE_CODE2_LSB = 4;
  localparam int TSD_DE_ADAPT2    = 7;
  localparam int TSD_MX_CODE_LSB  = 0;
  localparam int TSD_MX_AUTO      = 7;
  localparam int TSD_TR_NEG       = 4;
  localparam int TSD_DC_FBDIS     = 0;
  localparam int TSD_DC_EMPH_OFF  = 1;
  localparam int TSD_DC_FBSRC     = 2;
  localparam int TSD_DC_OUTEN     = 4;
  localparam int TSD_DC_OSCTEST   = 6;
  localparam int TSD_DC_OSCPULL   = 7;
  // ----------------------------------------
  // Codes
  // ----------------------------------------
  localparam logic [1:0] TSD_IDENT_OFF   = 2'h3;
  localparam logic [1:0] TSD_CH2_FM      = 2'h0;
  localparam logic [1:0] TSD_CH2_AM      = 2'h1;
  localparam logic [1:0] TSD_CH2_NICAM   = 2'h2;
  localparam logic [1:0] TSD_BW_XN       = 2'h1;
  localparam logic [1:0] TSD_ID_STEREO   = 2'h1;
  localparam logic [1:0] TSD_ID_DUAL     = 2'h2;
  localparam logic [3:0] TSD_TRIM_UNDEF  = 4'hF;
  localparam logic [4:0] TSD_TRIM_OFFSET = 5'h0F;
  localparam logic [2:0] TSD_MX_MONO1    = 3'h0;
  localparam logic [2:0] TSD_MX_DUAL     = 3'h2;
  localparam logic [2:0] TSD_MX_EUROPE   = 3'h4;
  localparam logic [2:0] TSD_MX_KOREA    = 3'h6;

  typedef enum logic [2:0] {
    TSD_SRC_CH1       = 3'h0,
    TSD_SRC_CH2       = 3'h1,
    TSD_SRC_EUR_LEFT  = 3'h2,
    TSD_SRC_SUM       = 3'h3,
    TSD_SRC_DIFF      = 3'h4,
    TSD_SRC_SUM_HALF  = 3'h5,
    TSD_SRC_DIFF_HALF = 3'h6
  } tsd_src_t;

  typedef enum logic [1:0] {
    TSD_BW_NARROW = 2'h0,
    TSD_BW_MEDIUM = 2'h1,
    TSD_BW_WIDE   = 2'h2,
    TSD_BW_EXTRA  = 2'h3
  } tsd_bw_t;

  typedef enum logic [1:0] {
    TSD_OUT_NICAM = 2'h0,
    TSD_OUT_FIRST = 2'h1,
    TSD_OUT_MONO  = 2'h2
  } tsd_out_t;
endpackage

// ==== verilog/tsd_fallback.sv ====
module tsd_fallback (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             active,
  input  wire logic             mono_pick,
  input  wire logic             err_valid,
  input  wire logic [7:0]       err_count,
  input  wire logic [7:0]       lower,
  input  wire logic [7:0]       upper,
  output tsd_pkg::tsd_out_t     analog_src,
  output tsd_pkg::tsd_out_t     digital_src
);
  import tsd_pkg::*;

  typedef enum logic {
    TSD_USE_NICAM    = 1'b0,
    TSD_USE_FALLBACK = 1'b1
  } tsd_fb_state_t;

  typedef struct packed {
    tsd_fb_state_t mode;
    tsd_out_t      analog_src;
    tsd_out_t      digital_src;
  } tsd_fb_t;

  tsd_fb_t st;
  tsd_fb_t next_st;

  always_comb begin
    next_st = st;
    if (ce) begin
      if (!active) begin
        next_st.mode = TSD_USE_NICAM;  // RULE22
      end else if (err_valid) begin
        // Gap between limits is hysteresis against source chatter
        unique case (st.mode)
          TSD_USE_NICAM: begin
            if (err_count > upper) begin
              next_st.mode = TSD_USE_FALLBACK;  // RULE24
            end
          end
          TSD_USE_FALLBACK: begin
            if (err_count < lower) begin
              next_st.mode = TSD_USE_NICAM;  // RULE23
            end
          end
        endcase
      end
      if (next_st.mode == TSD_USE_FALLBACK) begin
        next_st.analog_src  = mono_pick ? TSD_OUT_MONO : TSD_OUT_FIRST;  // RULE19
        next_st.digital_src = TSD_OUT_FIRST;  // RULE20
      end else begin
        next_st.analog_src  = TSD_OUT_NICAM;
        next_st.digital_src = TSD_OUT_NICAM;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '{TSD_USE_NICAM, TSD_OUT_NICAM, TSD_OUT_NICAM};
    end else begin
      st <= next_st;
    end
  end

  assign analog_src  = st.analog_src;
  assign digital_src = st.digital_src;

  chk_fallback_on_errors: assert property (@(posedge clk) disable iff (rst)  // RULE24
    ce && active && err_valid && err_count > upper |=> digital_src == TSD_OUT_FIRST)
    else $error("fallback not taken above upper limit");

  chk_nicam_reselect: assert property (@(posedge clk) disable iff (rst)  // RULE23
    ce && active && err_valid && err_count < lower |=> digital_src == TSD_OUT_NICAM)
    else $error("NICAM not reselected below lower limit");

  chk_disabled_stays: assert property (@(posedge clk) disable iff (rst)  // RULE22
    ce && !active |=> analog_src == TSD_OUT_NICAM && digital_src == TSD_OUT_NICAM)
    else $error("switching while auto-mute inactive");

  chk_digital_no_mono: assert property (@(posedge clk) disable iff (rst)  // RULE20
    digital_src != TSD_OUT_MONO)
    else $error("digital path fell back to mono input");
endmodule

// ==== verilog/tsd_config.sv ====
module tsd_config (
  input  wire logic              MCLK,
  input  wire logic              RST,
  input  wire logic              CE,
  input  wire logic              WR_EN,
  input  wire logic [7:0]        WR_ADDR,
  input  wire logic [7:0]        WR_DATA,
  input  wire logic [1:0]        IDENT_RESULT,
  input  wire logic              DAC_SELECTED,
  input  wire logic              ERR_VALID,
  input  wire logic [7:0]        ERR_COUNT,
  input  wire logic              NICAM_BIT,
  input  wire logic              NICAM_BITCLK,
  output logic                   FIRST_CARRIER_AM_SELECT,
  output logic [1:0]             SECOND_CARRIER_MODE,
  output logic [1:0]             IDENT_TIMING,
  output logic                   IDENT_RESET,
  output logic                   IDENT_REGION_SELECT,
  output tsd_pkg::tsd_bw_t       CH1_BANDWIDTH,
  output tsd_pkg::tsd_bw_t       CH2_BANDWIDTH,
  output logic                   CH2_FM_ALLOWED,
  output logic [2:0]             FIRST_EMPHASIS_CODE,
  output logic [2:0]             SECOND_EMPHASIS_CODE,
  output logic                   ADAPTIVE_EMPHASIS_FIRST,
  output logic                   ADAPTIVE_EMPHASIS_SECOND,
  output logic                   AUTO_DEMATRIX_ENABLE,
  output tsd_pkg::tsd_src_t      MATRIX_LEFT,
  output tsd_pkg::tsd_src_t      MATRIX_RIGHT,
  output logic signed [4:0]      TRIM1_GAIN_DB,
  output logic                   TRIM1_UNDEFINED,
  output logic signed [4:0]      TRIM2_GAIN_DB,
  output logic                   TRIM2_UNDEFINED,
  output logic signed [4:0]      MONO_GAIN_DB,
  output logic                   OSCILLATOR_TEST_ENABLE,
  output logic                   OSCILLATOR_PULL_LOW,
  output logic                   DIGITAL_EMPHASIS_ON,
  output logic                   SDATA_OUT,
  output logic                   SDATA_OE_N,
  output logic                   SCLK_OUT,
  output logic                   SCLK_OE_N,
  output tsd_pkg::tsd_out_t      ANALOG_SOURCE,
  output tsd_pkg::tsd_out_t      DIGITAL_SOURCE
);
  import tsd_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]        demod;
    logic [7:0]        deemph;
    logic [7:0]        matrix;
    logic [7:0]        trim1;
    logic [7:0]        trim2;
    logic [7:0]        digcfg;
    logic [7:0]        lower;
    logic [7:0]        upper;
    logic              ident_reset;
    tsd_bw_t           bw1;
    tsd_bw_t           bw2;
    logic              ch2_fm;
    tsd_src_t          left;
    tsd_src_t          right;
    logic signed [4:0] gain1;
    logic              undef1;
    logic signed [4:0] gain2;
    logic              undef2;
    logic              osc_test;
    logic              osc_pull;
    logic              sdata;
    logic              sclk;
    logic              emph_on;
    logic              serial_oe_n;
  } tsd_cfg_t;

  tsd_cfg_t st;
  tsd_cfg_t next_st;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic signed [4:0] trim_gain(input logic [7:0] t);
    logic [4:0] mag;
    mag = {1'b0, t[3:0]};
    if (t[TSD_TR_NEG]) begin
      trim_gain = signed'(mag - TSD_TRIM_OFFSET);  // RULE14
    end else begin
      trim_gain = signed'(mag);  // RULE14
    end
  endfunction

  function automatic logic trim_undef(input logic [7:0] t);
    trim_undef = t[TSD_TR_NEG] && (t[3:0] == TSD_TRIM_UNDEF);  // RULE14
  endfunction

  // Returns {left, right}; code 111 has no meaning and falls back to mono
  function automatic logic [5:0] matrix_map(input logic [2:0] code);
    unique case (code)  // RULE12
      3'h0:    matrix_map = {TSD_SRC_CH1, TSD_SRC_CH1};
      3'h1:    matrix_map = {TSD_SRC_CH2, TSD_SRC_CH2};
      3'h2:    matrix_map = {TSD_SRC_CH1, TSD_SRC_CH2};
      3'h3:    matrix_map = {TSD_SRC_CH2, TSD_SRC_CH1};
      3'h4:    matrix_map = {TSD_SRC_EUR_LEFT, TSD_SRC_CH2};
      3'h5:    matrix_map = {TSD_SRC_SUM_HALF, TSD_SRC_DIFF_HALF};
      3'h6:    matrix_map = {TSD_SRC_SUM, TSD_SRC_DIFF};
      default: matrix_map = {TSD_SRC_CH1, TSD_SRC_CH1};
    endcase
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic [2:0] mx_code;
  logic [5:0] mx_pair;
  logic [1:0] ch2_mode;
  logic [1:0] bw_code;

  always_comb begin
    next_st  = st;
    mx_code  = TSD_MX_MONO1;
    mx_pair  = '0;
    ch2_mode = st.demod[TSD_DM_CH2_LSB +: 2];
    bw_code  = {st.demod[TSD_DM_BW_HI], st.demod[TSD_DM_BW_LO]};
    if (CE) begin
      // Unlisted subaddresses belong to other blocks and are ignored here
      if (WR_EN) begin
        unique case (WR_ADDR)
          TSD_ADDR_DEMOD:  next_st.demod  = WR_DATA;
          TSD_ADDR_DEEMPH: next_st.deemph = WR_DATA;
          TSD_ADDR_MATRIX: next_st.matrix = WR_DATA;
          TSD_ADDR_TRIM1:  next_st.trim1  = WR_DATA;
          TSD_ADDR_TRIM2:  next_st.trim2  = WR_DATA;
          TSD_ADDR_DIGCFG: next_st.digcfg = WR_DATA;
          TSD_ADDR_LOWER:  next_st.lower  = WR_DATA;
          TSD_ADDR_UPPER:  next_st.upper  = WR_DATA;
          default: ;
        endcase
      end
      ch2_mode = next_st.demod[TSD_DM_CH2_LSB +: 2];
      bw_code  = {next_st.demod[TSD_DM_BW_HI], next_st.demod[TSD_DM_BW_LO]};

      // Timing code 11 holds the ident integrators in reset
      next_st.ident_reset = next_st.demod[TSD_DM_IDENT_LSB +: 2] == TSD_IDENT_OFF;  // RULE2 RULE5

      unique case (bw_code)  // RULE4
        2'h0: begin
          next_st.bw1 = TSD_BW_NARROW;
          next_st.bw2 = TSD_BW_NARROW;
        end
        2'h1: begin
          next_st.bw1 = TSD_BW_EXTRA;
          next_st.bw2 = TSD_BW_NARROW;
        end
        2'h2: begin
          next_st.bw1 = TSD_BW_MEDIUM;
          next_st.bw2 = TSD_BW_MEDIUM;
        end
        2'h3: begin
          next_st.bw1 = TSD_BW_WIDE;
          next_st.bw2 = TSD_BW_WIDE;
        end
      endcase
      // Extra-wide mode bars FM on channel 2
      next_st.ch2_fm = bw_code != TSD_BW_XN;  // RULE4

      if (next_st.matrix[TSD_MX_AUTO]) begin
        if (ch2_mode == TSD_CH2_NICAM) begin
          mx_code = TSD_MX_MONO1;  // RULE11
        end else if (IDENT_RESULT == TSD_ID_STEREO) begin
          mx_code = next_st.demod[TSD_DM_REGION] ? TSD_MX_KOREA : TSD_MX_EUROPE;  // RULE10 RULE13
        end else if (IDENT_RESULT == TSD_ID_DUAL) begin
          mx_code = TSD_MX_DUAL;  // RULE13
        end else begin
          mx_code = TSD_MX_MONO1;  // RULE13
        end
      end else begin
        mx_code = next_st.matrix[TSD_MX_CODE_LSB +: 3];  // RULE12
      end
      mx_pair       = matrix_map(mx_code);
      next_st.left  = tsd_src_t'(mx_pair[5:3]);
      next_st.right = tsd_src_t'(mx_pair[2:0]);

      next_st.gain1  = trim_gain(next_st.trim1);
      next_st.undef1 = trim_undef(next_st.trim1);
      next_st.gain2  = trim_gain(next_st.trim2);
      next_st.undef2 = trim_undef(next_st.trim2);

      // The oscillator only has a test mode while channel 2 is not NICAM
      next_st.osc_test = next_st.digcfg[TSD_DC_OSCTEST] && ch2_mode != TSD_CH2_NICAM;  // RULE17
      next_st.osc_pull = next_st.osc_test && next_st.digcfg[TSD_DC_OSCPULL];  // RULE17

      next_st.sdata = next_st.digcfg[TSD_DC_OUTEN] && NICAM_BIT;  // RULE18
      next_st.sclk  = next_st.digcfg[TSD_DC_OUTEN] && NICAM_BITCLK;  // RULE18
      // Inverted levels are registered too, so no pin hangs behind a gate
      next_st.emph_on     = !next_st.digcfg[TSD_DC_EMPH_OFF];  // RULE21
      next_st.serial_oe_n = !next_st.digcfg[TSD_DC_OUTEN];  // RULE18
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      st       <= '0;
      st.lower <= TSD_RST_LOWER;  // RULE23
      st.upper <= TSD_RST_UPPER;  // RULE24
      st.emph_on     <= 1'b1;
      st.serial_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Auto-mute source selection
  // ----------------------------------------
  tsd_fallback u_fallback (
    .clk         (MCLK),
    .rst         (RST),
    .ce          (CE),
    .active      (st.demod[TSD_DM_CH2_LSB +: 2] == TSD_CH2_NICAM && !st.digcfg[TSD_DC_FBDIS]),  // RULE22
    .mono_pick   (st.digcfg[TSD_DC_FBSRC] && DAC_SELECTED),  // RULE19
    .err_valid   (ERR_VALID),
    .err_count   (ERR_COUNT),
    .lower       (st.lower),
    .upper       (st.upper),
    .analog_src  (ANALOG_SOURCE),
    .digital_src (DIGITAL_SOURCE)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign FIRST_CARRIER_AM_SELECT  = st.demod[TSD_DM_CH1AM];  // RULE1
  assign SECOND_CARRIER_MODE      = st.demod[TSD_DM_CH2_LSB +: 2];  // RULE3
  assign IDENT_TIMING             = st.demod[TSD_DM_IDENT_LSB +: 2];  // RULE2
  assign IDENT_RESET              = st.ident_reset;
  assign IDENT_REGION_SELECT      = st.demod[TSD_DM_REGION];
  assign CH1_BANDWIDTH            = st.bw1;
  assign CH2_BANDWIDTH            = st.bw2;
  assign CH2_FM_ALLOWED           = st.ch2_fm;
  // Every de-emphasis response is normalised to 0 dB at the low reference point
  assign FIRST_EMPHASIS_CODE      = st.deemph[TSD_DE_CODE1_LSB +: 3];  // RULE6 RULE7 RULE9
  assign SECOND_EMPHASIS_CODE     = st.deemph[TSD_DE_CODE2_LSB +: 3];  // RULE6 RULE7 RULE9
  assign ADAPTIVE_EMPHASIS_FIRST  = st.deemph[TSD_DE_ADAPT1];  // RULE8
  assign ADAPTIVE_EMPHASIS_SECOND = st.deemph[TSD_DE_ADAPT2];  // RULE8
  assign AUTO_DEMATRIX_ENABLE     = st.matrix[TSD_MX_AUTO];  // RULE10
  assign MATRIX_LEFT              = st.left;
  assign MATRIX_RIGHT             = st.right;
  assign TRIM1_GAIN_DB            = st.gain1;
  assign TRIM1_UNDEFINED          = st.undef1;
  assign TRIM2_GAIN_DB            = st.gain2;
  assign TRIM2_UNDEFINED          = st.undef2;
  assign MONO_GAIN_DB             = st.gain1;  // RULE15
  assign OSCILLATOR_TEST_ENABLE   = st.osc_test;
  assign OSCILLATOR_PULL_LOW      = st.osc_pull;
  assign DIGITAL_EMPHASIS_ON      = st.emph_on;  // RULE9 RULE21
  assign SDATA_OUT                = st.sdata;
  assign SCLK_OUT                 = st.sclk;
  assign SDATA_OE_N               = st.serial_oe_n;  // RULE18
  assign SCLK_OE_N                = st.serial_oe_n;  // RULE18

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_ch1_am_mode: assert property (@(posedge MCLK) disable iff (RST)  // RULE1
    CE && WR_EN && WR_ADDR == TSD_ADDR_DEMOD |=> FIRST_CARRIER_AM_SELECT == $past(WR_DATA[0]))
    else $error("channel 1 mode not taken from write");

  chk_ident_off_reset: assert property (@(posedge MCLK) disable iff (RST)  // RULE2
    CE && WR_EN && WR_ADDR == TSD_ADDR_DEMOD |=> IDENT_RESET == ($past(WR_DATA[7:6]) == 2'h3))
    else $error("ident reset does not follow timing code 11");

  chk_ch2_mode_write: assert property (@(posedge MCLK) disable iff (RST)  // RULE3
    CE && WR_EN && WR_ADDR == TSD_ADDR_DEMOD |=> SECOND_CARRIER_MODE == $past(WR_DATA[3:2]))
    else $error("channel 2 mode not taken from write");

  chk_extra_wide: assert property (@(posedge MCLK) disable iff (RST)  // RULE4
    CE && WR_EN && WR_ADDR == TSD_ADDR_DEMOD && WR_DATA[4] == 1'b0 && WR_DATA[1] == 1'b1
    |=> CH1_BANDWIDTH == TSD_BW_EXTRA && CH2_BANDWIDTH == TSD_BW_NARROW && !CH2_FM_ALLOWED)
    else $error("extra wide bandwidth mode wrong");

  chk_deemph_nibbles: assert property (@(posedge MCLK) disable iff (RST)  // RULE6
    CE && WR_EN && WR_ADDR == TSD_ADDR_DEEMPH
    |=> FIRST_EMPHASIS_CODE == $past(WR_DATA[2:0]) && SECOND_EMPHASIS_CODE == $past(WR_DATA[6:4])
        && ADAPTIVE_EMPHASIS_SECOND == $past(WR_DATA[7]))
    else $error("de-emphasis nibbles misrouted");

  chk_auto_nicam_mono: assert property (@(posedge MCLK) disable iff (RST)  // RULE11
    AUTO_DEMATRIX_ENABLE && SECOND_CARRIER_MODE == TSD_CH2_NICAM && $stable(SECOND_CARRIER_MODE)
    |-> MATRIX_LEFT == TSD_SRC_CH1 && MATRIX_RIGHT == TSD_SRC_CH1)
    else $error("auto dematrix not mono under NICAM");

  chk_manual_europe: assert property (@(posedge MCLK) disable iff (RST)  // RULE12
    CE && WR_EN && WR_ADDR == TSD_ADDR_MATRIX && WR_DATA == 8'h04
    |=> MATRIX_LEFT == TSD_SRC_EUR_LEFT && MATRIX_RIGHT == TSD_SRC_CH2)
    else $error("manual Europe stereo matrix wrong");

  chk_trim_minus_one: assert property (@(posedge MCLK) disable iff (RST)  // RULE14
    CE && WR_EN && WR_ADDR == TSD_ADDR_TRIM1 && WR_DATA == 8'h1E
    |=> TRIM1_GAIN_DB == -5'sd1 && !TRIM1_UNDEFINED)
    else $error("trim code 1E is not -1 dB");

  chk_mono_gain_tied: assert property (@(posedge MCLK) disable iff (RST)  // RULE15
    CE && WR_EN && WR_ADDR == TSD_ADDR_TRIM1
    |=> MONO_GAIN_DB == {1'b0, $past(WR_DATA[3:0])} - ($past(WR_DATA[4]) ? 5'd15 : 5'd0))
    else $error("mono feed gain differs from channel 1 trim");

  chk_serial_hiz: assert property (@(posedge MCLK) disable iff (RST)  // RULE18
    SDATA_OE_N |-> SCLK_OE_N && !SDATA_OUT && !SCLK_OUT)
    else $error("serial outputs active while disabled");

  chk_nicam_deemph: assert property (@(posedge MCLK) disable iff (RST)  // RULE21
    CE && WR_EN && WR_ADDR == TSD_ADDR_DIGCFG |=> DIGITAL_EMPHASIS_ON == !$past(WR_DATA[1]))
    else $error("NICAM de-emphasis sense inverted");
endmodule

// ==== testbench/tsd_host.sv ====
module tsd_host (
  input  wire logic  clk,
  output logic       wr_en = 1'b0,
  output logic [7:0] wr_addr = 8'h00,
  output logic [7:0] wr_data = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // Data is inverted once the strobe drops so a stale byte never passes for a fresh one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    wr_en   = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(posedge clk);
    #1;
    wr_en   = 1'b0;
    wr_data = ~d;
  endtask
endmodule

// ==== testbench/tsd_config_tb.sv ====
module tsd_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tsd_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1, ce = 1'b1, dac = 1'b0, ev = 1'b0, nb = 1'b1;
  logic              we, idres, oe_n, sdo, osc, dem;
  logic              u1, u2, a1, a2, fc, rs, fm2, ade, pl, sco, scoe;
  logic [1:0]        cm, it;
  logic [1:0]        idr = 2'h0;
  logic [7:0]        ec = 8'h00, wa, wd;
  logic [2:0]        e1, e2;
  logic signed [4:0] t1, t2, mg;
  logic [27:0]       r;
  tsd_src_t          ml, mr;
  tsd_bw_t           b1, b2;
  tsd_out_t          asrc, dsrc;
  int                n_mismatch, compares;
  // Row: subaddress, data, ident result, expected view of the written register
  logic [27:0]       rows [31] = '{
    28'h0B00000, 28'h0B01011, 28'h0B02001, 28'h0B03010, 28'h0B04021, 28'h0B05056, 28'h0B06034,
    28'h0B07000, 28'h0F01000, 28'h1B01000, 28'h09C0080, 28'h0940000, 28'h0980000, 28'h0B87000,
    28'h0900121, 28'h0920134, 28'h0920201, 28'h0920300, 28'h09E8180, 28'h0A43043, 28'h0A10010,
    28'h0AAA0AA, 28'h0C0F00F, 28'h0C10011, 28'h0C1E01F, 28'h0D0501F, 28'h0EC0005, 28'h09C01A1,
    28'h0EC010D, 28'h0E12102, 28'h0E00105};
  tsd_host i_tsd_host (.clk(clk), .wr_en(we), .wr_addr(wa), .wr_data(wd));
  tsd_config i_tsd_config (.MCLK(clk), .RST(rst), .CE(ce), .WR_EN(we), .WR_ADDR(wa), .WR_DATA(wd),
    .IDENT_RESULT(idr), .DAC_SELECTED(dac), .ERR_VALID(ev), .ERR_COUNT(ec), .NICAM_BIT(nb), .NICAM_BITCLK(~nb),
    .FIRST_CARRIER_AM_SELECT(fc), .SECOND_CARRIER_MODE(cm), .IDENT_TIMING(it), .IDENT_RESET(idres),
    .IDENT_REGION_SELECT(rs), .CH1_BANDWIDTH(b1), .CH2_BANDWIDTH(b2), .CH2_FM_ALLOWED(fm2),
    .FIRST_EMPHASIS_CODE(e1), .SECOND_EMPHASIS_CODE(e2), .ADAPTIVE_EMPHASIS_FIRST(a1),
    .ADAPTIVE_EMPHASIS_SECOND(a2), .AUTO_DEMATRIX_ENABLE(ade), .MATRIX_LEFT(ml), .MATRIX_RIGHT(mr),
    .TRIM1_GAIN_DB(t1), .TRIM1_UNDEFINED(u1), .TRIM2_GAIN_DB(t2), .TRIM2_UNDEFINED(u2), .MONO_GAIN_DB(mg),
    .OSCILLATOR_TEST_ENABLE(osc), .OSCILLATOR_PULL_LOW(pl), .DIGITAL_EMPHASIS_ON(dem), .SDATA_OUT(sdo),
    .SDATA_OE_N(oe_n), .SCLK_OUT(sco), .SCLK_OE_N(scoe), .ANALOG_SOURCE(asrc), .DIGITAL_SOURCE(dsrc));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic err(input logic [7:0] c, input logic [7:0] x);
    ev = 1'b1;
    ec = c;
    @(posedge clk);
    #1;
    ev = 1'b0;
    settle();
    chk({4'h0, asrc, dsrc}, x);
  endtask
  // Trim rows on the second trim register look at the mono gain, which must follow trim one
  function automatic logic [7:0] obs(input logic [7:0] a);
    case (a)
      TSD_ADDR_TRIM1, TSD_ADDR_TRIM2: obs = {3'h0, a[0] ? mg : t1};
      TSD_ADDR_DEEMPH: obs = {a2, e2, a1, e1};
      TSD_ADDR_DIGCFG: obs = {4'h0, osc, oe_n, sdo, dem};
      default: obs = {idres, ml, 1'b0, mr};
    endcase
  endfunction
  task automatic final_report();
    $display("compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial forever #5 clk = ~clk;
  initial begin
    #20000;
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(obs(TSD_ADDR_DIGCFG), 8'h05);
    chk({4'h0, asrc, dsrc}, 8'h00);
    $display("reset test done");
    foreach (rows[i]) begin
      r = rows[i];
      idr = r[9:8];
      i_tsd_host.wr(r[27:20], r[19:12]);
      settle();
      chk(obs(r[27:20]), r[7:0]);
    end
    $display("register table done");
    i_tsd_host.wr(TSD_ADDR_DIGCFG, 8'h10);
    nb = 1'b0;
    settle();
    chk(obs(TSD_ADDR_DIGCFG), 8'h01);
    chk({6'h0, sco, scoe}, 8'h02);
    $display("serial output test done");
    i_tsd_host.wr(TSD_ADDR_DEMOD, 8'hC8);
    i_tsd_host.wr(TSD_ADDR_DIGCFG, 8'h04);
    dac = 1'b1;
    err(8'h50, 8'h00);
    err(8'h51, 8'h09);
    dac = 1'b0;
    err(8'h14, 8'h05);
    err(8'h13, 8'h00);
    err(8'h51, 8'h05);
    i_tsd_host.wr(TSD_ADDR_DIGCFG, 8'h05);
    settle();
    chk({4'h0, asrc, dsrc}, 8'h00);
    err(8'hFF, 8'h00);
    $display("fallback test done");
    i_tsd_host.wr(TSD_ADDR_DIGCFG, 8'h00);
    i_tsd_host.wr(TSD_ADDR_UPPER, 8'h20);
    err(8'h21, 8'h05);
    i_tsd_host.wr(TSD_ADDR_LOWER, 8'h1C);
    err(8'h1B, 8'h00);
    // With the enable low neither a write nor an error report may move anything
    ce = 1'b0;
    i_tsd_host.wr(TSD_ADDR_TRIM1, 8'h03);
    err(8'h21, 8'h00);
    ce = 1'b1;
    chk({3'h0, t1}, 8'h1F);
    $display("limit and enable test done");
    rst = 1'b1;
    settle();
    rst = 1'b0;
    chk(obs(TSD_ADDR_DIGCFG), 8'h05);
    chk({3'h0, t1}, 8'h00);
    i_tsd_host.wr(TSD_ADDR_DEMOD, 8'h08);
    err(8'h50, 8'h00);
    err(8'h51, 8'h05);
    err(8'h14, 8'h05);
    $display("mid-run reset test done");
    i_tsd_host.wr(TSD_ADDR_DEMOD, 8'h67);
    i_tsd_host.wr(TSD_ADDR_MATRIX, 8'h80);
    i_tsd_host.wr(TSD_ADDR_DIGCFG, 8'hC0);
    i_tsd_host.wr(TSD_ADDR_TRIM1, 8'h1F);
    i_tsd_host.wr(TSD_ADDR_TRIM2, 8'h05);
    settle();
    chk({it, rs, b1, cm, fc}, 8'h7B);
    chk({b2, fm2, ade, pl, scoe, sco, 1'b0}, 8'h1C);
    chk(obs(TSD_ADDR_MATRIX), 8'h34);
    chk({u1, u2, 1'b0, t2}, 8'h85);
    chk(obs(TSD_ADDR_TRIM2), 8'h00);
    $display("output view test done");
    final_report();
  end
endmodule
